// file: aof_filter.sv
`timescale 1ns/10ps
`include "aof_map.svh"
module aof_filter (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        smp_valid_i,
  input  wire logic [4:0]  smp_chan_i,
  input  wire logic [11:0] smp_data_i,
  output logic             adc_irq_o,
  output logic             irq_o
);
  //////////////////////////////////////////////////////////////////////
  // control register and decode
  logic [15:0]         ctrl_q;
  logic [15:0]         result_q;
  logic                ready_q;
  logic [1:0]          status_q;
  logic [1:0]          mask_q;
  logic [8:0]          count_q;
  aof_pkg::aof_state_t state_q;
  aof_acc_if           acc_bus ();

  wire       wr_ctrl   = wr_i && (addr_i == `AOF_ADDR_CONTROL);
  wire       wr_mask   = wr_i && (addr_i == `AOF_ADDR_MASK);
  wire       rd_result = rd_i && (addr_i == `AOF_ADDR_RESULT);
  wire       rd_status = rd_i && (addr_i == `AOF_ADDR_STATUS);
  wire       on        = ctrl_q[`AOF_BIT_ON];
  wire [1:0] mode_raw  = ctrl_q[`AOF_BIT_MODE_HI:`AOF_BIT_MODE_LO];
  wire [2:0] ratio     = ctrl_q[`AOF_BIT_RATIO_HI:`AOF_BIT_RATIO_LO];
  wire [4:0] sel       = ctrl_q[`AOF_BIT_SEL_HI:`AOF_BIT_SEL_LO];
  // reserved modes behave as neither; the filter just stays idle
  wire is_avg  = (aof_pkg::aof_mode_t'(mode_raw) == aof_pkg::AOF_MODE_AVERAGE);
  wire is_ovs  = (aof_pkg::aof_mode_t'(mode_raw) == aof_pkg::AOF_MODE_OVERSAMPLE);
  wire running = on && (is_avg || is_ovs);

  //////////////////////////////////////////////////////////////////////
  // sample selection and count
  // codes above the last input never match a real channel
  wire take = running && smp_valid_i && (smp_chan_i == sel)
              && (sel <= `AOF_LAST_INPUT);
  // averaging doubles per code from 2x; oversampling keeps ratio[1:0]+1 fraction bits with
  // 4x at 000 and 128x at 111, so the upper code half takes one doubling fewer samples
  wire [3:0] frac   = {2'h0, ratio[1:0]} + 4'h1;
  wire [3:0] log_n  = is_avg ? ({1'b0, ratio} + 4'h1) : ((frac << 1) - {3'h0, ratio[2]});
  wire [8:0] need   = 9'h001 << log_n;
  wire       last   = take && ((count_q + 9'h001) == need);
  wire [19:0] total = acc_bus.sum + {8'h00, smp_data_i};
  // oversampling drops all but the fraction bits; averaging drops all of log_n
  wire [3:0] shift  = is_avg ? log_n : (log_n - frac);
  wire [19:0] shifted = total >> shift;
  wire [15:0] new_res = shifted[15:0];
  wire first = take && (state_q == aof_pkg::AOF_ST_IDLE);

  assign acc_bus.add    = take && !last;
  assign acc_bus.clear  = first || last || !running;
  assign acc_bus.sample = smp_data_i;

  aof_acc u_acc (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .acc     (acc_bus.acc)
  );

  // sequence through one block of samples
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= aof_pkg::AOF_ST_IDLE;
      count_q <= 9'h000;
    end else if (ce_i) begin
      if (!running || last || wr_ctrl) begin
        state_q <= aof_pkg::AOF_ST_IDLE;
        count_q <= 9'h000;
      end else if (take) begin
        state_q <= aof_pkg::AOF_ST_GATHER;
        count_q <= count_q + 9'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers; a completing result wins over the read that clears ready
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q   <= `AOF_RST_CONTROL;
      result_q <= 16'h0000;
      ready_q  <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_i;
      end
      if (last) begin
        result_q <= new_res;
        ready_q  <= 1'b1;
      end else if (!on || rd_result) begin
        ready_q  <= 1'b0;
      end
    end
  end

  // sticky status: bit0 result done, bit1 reserved select used
  wire [1:0] events = {running && smp_valid_i && (sel > `AOF_LAST_INPUT), last};
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_q <= 2'h0;
      mask_q   <= `AOF_RST_MASK;
    end else if (ce_i) begin
      status_q <= events | (rd_status ? 2'h0 : status_q);
      if (wr_mask) begin
        mask_q <= wdata_i[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data and interrupts
  wire [15:0] ctrl_view = {ctrl_q[15:9], ready_q, 3'h0, ctrl_q[4:0]};
  wire [15:0] rd_mux = (addr_i == `AOF_ADDR_CONTROL) ? ctrl_view :
                       (addr_i == `AOF_ADDR_RESULT)  ? result_q  :
                       (addr_i == `AOF_ADDR_STATUS)  ? {14'h0000, status_q} :
                       (addr_i == `AOF_ADDR_MASK)    ? {14'h0000, mask_q} : 16'h0000;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o   <= 16'h0000;
      adc_irq_o <= 1'b0;
      irq_o     <= 1'b0;
    end else if (ce_i) begin
      rdata_o   <= rd_i ? rd_mux : 16'h0000;
      adc_irq_o <= last && ctrl_q[`AOF_BIT_IRQ_EN];
      irq_o     <= |(status_q & mask_q);
    end
  end

  // a finished block raises the common interrupt next cycle only if enabled
  irq_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> (adc_irq_o == ($past(last) && $past(ctrl_q[`AOF_BIT_IRQ_EN]))))
    else $error("common interrupt does not follow result");
  ready_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && last) |=> ready_q)
    else $error("ready not set after result");
  ready_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !on && !last) |=> !ready_q)
    else $error("ready kept while filter off");
  reserved_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(is_avg || is_ovs) |-> !take)
    else $error("reserved mode took a sample");
  chan_match_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    take |-> (smp_chan_i == sel))
    else $error("sample from unselected input");
  bad_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sel > `AOF_LAST_INPUT) |-> !take)
    else $error("reserved select took a sample");
  avg_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (last && is_avg) |-> (count_q == ((9'h002 << ratio) - 9'h001)))
    else $error("averaging count wrong");
  ovs_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (last && is_ovs) |-> (count_q == (((ratio[2] ? 9'h002 : 9'h004) << {ratio[1:0], 1'b0}) - 9'h001)))
    else $error("oversampling count wrong");

  //////////////////////////////////////////////////////////////////////
  // block sequencing: the count never runs past the block it fills, so a
  // ratio change can only take effect through the restart on a write
  idle_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_q == aof_pkg::AOF_ST_IDLE) |-> (count_q == 9'h000))
    else $error("idle sequencer holds a count");
  count_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    running |-> (count_q < need))
    else $error("sample count past block size");
  write_restart_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && wr_ctrl) |=> (count_q == 9'h000))
    else $error("control write kept a partial block");
  first_sample_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && first) |=> (acc_bus.sum == {8'h00, $past(smp_data_i)}))
    else $error("new block does not start from its sample");
  // results never spill past their format, whatever the samples hold
  avg_width_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (last && is_avg) |-> (shifted[19:12] == 8'h00))
    else $error("average wider than twelve bits");
  ovs_width_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (last && is_ovs) |-> (shifted[19:16] == 4'h0))
    else $error("oversampled result wider than sixteen bits");

  //////////////////////////////////////////////////////////////////////
  // registers and flags; a read that meets a completing block leaves
  // ready set, otherwise the read clears it
  ready_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && rd_result && !last) |=> !ready_q)
    else $error("result read left ready set");
  off_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !on |-> !take)
    else $error("disabled filter took a sample");
  result_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !last) |=> $stable(result_q))
    else $error("result changed without a block");
  ctrl_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && wr_ctrl) |=> (ctrl_q == $past(wdata_i)))
    else $error("control write lost");
  // status set wins over the read that clears it
  status_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && last) |=> status_q[0])
    else $error("done status not set");
  status_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && rd_status && !last) |=> !status_q[0])
    else $error("status read did not clear done");
  // enable clear keeps the common interrupt quiet
  irq_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !ctrl_q[`AOF_BIT_IRQ_EN]) |=> !adc_irq_o)
    else $error("common interrupt while disabled");
  // read data stands for one cycle only
  rdata_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && !rd_i) |=> (rdata_o == 16'h0000))
    else $error("read data without a read");
  // a low clock enable freezes every register and output
  ce_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !ce_i |=> ($stable(ctrl_q) && $stable(count_q) && $stable(ready_q) && $stable(status_q)
               && $stable(rdata_o) && $stable(irq_o)))
    else $error("state moved with clock enable low");
endmodule

// file: aof_map.svh
`ifndef AOF_MAP_SVH
`define AOF_MAP_SVH

// register offsets (plain port word addresses)
`define AOF_ADDR_CONTROL   4'h0
`define AOF_ADDR_RESULT    4'h1
`define AOF_ADDR_STATUS    4'h2
`define AOF_ADDR_MASK      4'h3
// control field positions
`define AOF_BIT_ON         15
`define AOF_BIT_MODE_HI    14
`define AOF_BIT_MODE_LO    13
`define AOF_BIT_RATIO_HI   12
`define AOF_BIT_RATIO_LO   10
`define AOF_BIT_IRQ_EN     9
`define AOF_BIT_READY      8
`define AOF_BIT_SEL_HI     4
`define AOF_BIT_SEL_LO     0
// reset values
`define AOF_RST_CONTROL    16'h0000
`define AOF_RST_MASK       2'h0
// highest legal input number
`define AOF_LAST_INPUT     5'h15
`endif

// file: aof_pkg.sv
package aof_pkg;
  typedef enum logic [1:0] {
    AOF_MODE_OVERSAMPLE = 2'h0,
    AOF_MODE_RSVD_A     = 2'h1,
    AOF_MODE_RSVD_B     = 2'h2,
    AOF_MODE_AVERAGE    = 2'h3
  } aof_mode_t;
  typedef enum logic {
    AOF_ST_IDLE,
    AOF_ST_GATHER
  } aof_state_t;
endpackage

// file: aof_if.sv
`timescale 1ns/10ps
// accumulator control and its answer travel together
interface aof_acc_if;
  logic        clear;
  logic        add;
  logic [11:0] sample;
  logic [19:0] sum;
  modport ctrl (output clear, output add, output sample, input sum);
  modport acc  (input clear, input add, input sample, output sum);
endinterface

// file: aof_acc.sv
`timescale 1ns/10ps
// sample accumulator; 256 x 12 bits needs 20 bits
module aof_acc (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  aof_acc_if.acc    acc
);
  logic [19:0] sum_q;
  logic [19:0] sum_d;

  assign sum_d   = acc.clear ? 20'h00000 : (sum_q + {8'h00, acc.sample});
  assign acc.sum = sum_q;

  // clear and add together start a fresh sum with this sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sum_q <= 20'h00000;
    end else if (ce_i && (acc.add || acc.clear)) begin
      sum_q <= acc.add ? (acc.clear ? {8'h00, acc.sample} : sum_d) : 20'h00000;
    end
  end
endmodule

// file: aof_adc_model.sv
`timescale 1ns/10ps
// stands in for the adc result path: one conversion result per call
module aof_adc_model (
  input  wire logic        clk_i,
  output logic             valid_o,
  output logic [4:0]       chan_o,
  output logic [11:0]      data_o
);
  initial begin
    valid_o = 1'b0;
    chan_o  = 5'h00;
    data_o  = 12'h000;
  end
  // between results the data lines carry the inverse, so a stale value never passes
  task automatic send(input logic [4:0] ch, input logic [11:0] d);
    @(posedge clk_i);
    valid_o <= 1'b1;
    chan_o  <= ch;
    data_o  <= d;
    @(posedge clk_i);
    valid_o <= 1'b0;
    data_o  <= ~d;
  endtask
endmodule

// file: tb_adc_oversampling_average_filter.sv
`timescale 1ns/10ps
module tb_adc_oversampling_average_filter;
  logic        clk_i, rst_b_i, ce_i, wr_i, rd_i, smp_valid_i, adc_irq_o, irq_o;
  logic [3:0]  addr_i;
  logic [4:0]  smp_chan_i;
  logic [11:0] smp_data_i;
  logic [15:0] wdata_i, rdata_o, v;
  int          n_errors, check_count, irq_seen, cycles;

  aof_filter u_aof_filter (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .smp_valid_i(smp_valid_i), .smp_chan_i(smp_chan_i),
    .smp_data_i(smp_data_i), .adc_irq_o(adc_irq_o), .irq_o(irq_o));
  aof_adc_model u_aof_adc_model (.clk_i(clk_i), .valid_o(smp_valid_i), .chan_o(smp_chan_i), .data_o(smp_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 check(rdata_o, exp);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // averaging 2x on input 5, a stray sample from input 6 in between
  task automatic t_avg;
    wr(4'h3, 16'h0001);
    wr(4'h0, 16'hE205);
    irq_seen = 0;
    u_aof_adc_model.send(5'h05, 12'h100);
    u_aof_adc_model.send(5'h06, 12'hFFF);
    u_aof_adc_model.send(5'h05, 12'h103);
    rd(4'h0, 16'hE305);
    check(16'(irq_seen), 16'h0001);
    check(16'(irq_o), 16'h0001);
    rd(4'h1, 16'h0101);
    rd(4'h0, 16'hE205);
    rd(4'h2, 16'h0001);
    @(posedge clk_i);
    #1 check(16'(irq_o), 16'h0000);
  endtask
  // oversampling at both ends of the ratio range, interrupt enable clear
  task automatic t_ovs;
    wr(4'h0, 16'h8003);
    irq_seen = 0;
    for (int i = 1; i <= 4; i++) u_aof_adc_model.send(5'h03, 12'(i));
    rd(4'h1, 16'h0005);
    wr(4'h0, 16'h9C15);
    repeat (128) u_aof_adc_model.send(5'h15, 12'h001);
    rd(4'h1, 16'h0010);
    check(16'(irq_seen), 16'h0000);
  endtask
  // turning the filter off drops a pending ready; unmapped read gives zero
  task automatic t_off;
    wr(4'h0, 16'h8003);
    repeat (4) u_aof_adc_model.send(5'h03, 12'h010);
    wr(4'h0, 16'h0003);
    rd(4'h0, 16'h0003);
    rd(4'h7, 16'h0000);
  endtask
  // a sample under a low clock enable is lost; reserved mode idles; reset mid-run
  task automatic t_hold;
    wr(4'h0, 16'h8003);
    u_aof_adc_model.send(5'h03, 12'h010);
    u_aof_adc_model.send(5'h03, 12'h020);
    ce_i <= 1'b0;
    u_aof_adc_model.send(5'h03, 12'hFFF);
    ce_i <= 1'b1;
    u_aof_adc_model.send(5'h03, 12'h030);
    u_aof_adc_model.send(5'h03, 12'h040);
    rd(4'h1, 16'h0050);
    wr(4'h0, 16'hA003);
    repeat (4) u_aof_adc_model.send(5'h03, 12'h010);
    rd(4'h0, 16'hA003);
    rd(4'h1, 16'h0050);
    rd(4'h3, 16'h0001);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, 16'h0000);
    check(16'(irq_o), 16'h0000);
    rd(4'h3, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (adc_irq_o === 1'b1) irq_seen++;
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    {rst_b_i, wr_i, rd_i} = 3'h0;
    ce_i    = 1'b1;
    addr_i  = 4'h0;
    wdata_i = 16'h0000;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h0, 16'h0000);
    t_avg();
    t_ovs();
    t_off();
    t_hold();
    conclude();
  end
endmodule
